/* File: hw/atu_trigger.v */
// Trigger generation and qualification unit with its register set
`timescale 1ns/1ps
`include "atu_regs.vh"

module atu_trigger #(
	parameter BUF_BYTES = 32'h00800000, // Buffer size in bytes
	parameter SMP_W     = 24,           // Raw sample width
	parameter MAG_W     = 10,           // Log magnitude width, 0.376 dB steps
	parameter PH_W      = 16            // Oscillator phase width
) (
	// Clock and reset
	input  wire             i_mclk,
	input  wire             i_arst_n,
	// Register bus
	input  wire             i_reg_sel,
	input  wire             i_reg_wr,
	input  wire [3:0]       i_reg_addr,
	input  wire [15:0]      i_reg_wdata,
	output reg  [15:0]      o_reg_rdata,
	// Sample stream and events
	input  wire             i_smp_valid,
	input  wire [SMP_W-1:0] i_raw_smp,
	input  wire             i_raw_ovl,
	input  wire [MAG_W-1:0] i_mag_db,
	input  wire             i_out_strobe,
	input  wire [PH_W-1:0]  i_lo_phase,
	input  wire             i_reconfig,
	input  wire             i_panel_trig,
	// System status inputs
	input  wire             i_errq_nonempty,
	input  wire             i_cmd_busy,
	input  wire             i_hw_applied,
	input  wire [1:0]       i_loop_state,
	input  wire             i_prearm_met,
	input  wire             i_slot_select,
	// Handshake line, open drain
	input  wire             i_hs_line,
	output reg              o_hs_line_o,
	output reg              o_hs_line_oe,
	// Event outputs and lamps
	output reg              o_trig,
	output reg              o_delay_err,
	output reg              o_lamp_access,
	output reg              o_lamp_ovl
);

	// ==========================================================
	// Pin synchronisers
	// Peers move the handshake line on their own timing, so it is treated
	// like any other pin and never read before the second flop
	reg [1:0] panel_sync_q;
	reg [1:0] slot_sync_q;
	reg [1:0] hs_sync_q;
	wire      panel_s = panel_sync_q[1];
	wire      slot_s  = slot_sync_q[1];
	wire      hs_rel  = hs_sync_q[1];   // High means released

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			panel_sync_q <= 2'h0;
			slot_sync_q  <= 2'h0;
			hs_sync_q    <= 2'h0;
		end else begin
			panel_sync_q <= {panel_sync_q[0], i_panel_trig};
			slot_sync_q  <= {slot_sync_q[0], i_slot_select};
			hs_sync_q    <= {hs_sync_q[0], i_hs_line};
		end
	end

	// ==========================================================
	// Trigger settings registers
	reg [2:0]       src_q;
	reg [24:0]      delay_q;
	reg [8:0]       adclvl_q;
	reg [9:0]       maglvl_q;
	reg             slope_q;
	reg             gen_q;
	reg             phcap_q;
	wire            wr = i_reg_sel & i_reg_wr;

	// Sign-extended delay compared against both limits
	// The lower bound follows the buffer size parameter
	function dly_bad;
		input [24:0] d;
		reg signed [25:0] sd;
		reg signed [25:0] lo;
		begin
			sd = {d[24], d};
			lo = $signed({1'b0, `ATU_DLY_PRE_BASE}) - $signed({1'b0, BUF_BYTES[27:3]});
			dly_bad = (sd > $signed({1'b0, `ATU_DLY_POST_MAX})) || (sd < lo);
		end
	endfunction

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			src_q       <= `ATU_RST_SRC;
			delay_q     <= `ATU_RST_DELAY;
			adclvl_q    <= `ATU_RST_ADCLEVEL;
			maglvl_q    <= `ATU_RST_MAGLEVEL;
			slope_q     <= `ATU_RST_SLOPE;
			gen_q       <= `ATU_RST_GEN;
			phcap_q     <= 1'b1;
			o_delay_err <= 1'b0;
		end else begin
			if (wr && i_reg_addr == `ATU_REG_TRIG_CFG) begin
				src_q   <= i_reg_wdata[2:0];
				slope_q <= i_reg_wdata[4];
				gen_q   <= i_reg_wdata[5];
			end
			// Delay is kept even when out of range
			if (wr && i_reg_addr == `ATU_REG_DELAY_LO)
				delay_q[15:0] <= i_reg_wdata;
			if (wr && i_reg_addr == `ATU_REG_DELAY_HI) begin
				delay_q[24:16] <= i_reg_wdata[8:0];
				o_delay_err    <= dly_bad({i_reg_wdata[8:0], delay_q[15:0]});
			end else if (wr && i_reg_addr == `ATU_REG_CTRL && i_reg_wdata[1])
				o_delay_err <= 1'b0;
			if (wr && i_reg_addr == `ATU_REG_ADCLEVEL)
				adclvl_q <= i_reg_wdata[8:0];
			if (wr && i_reg_addr == `ATU_REG_MAGLEVEL)
				maglvl_q <= i_reg_wdata[9:0];
			// Reconfiguration wins over a re-arm in the same cycle
			if (i_reconfig)
				phcap_q <= 1'b0;
			else if (wr && i_reg_addr == `ATU_REG_CTRL && i_reg_wdata[0])
				phcap_q <= 1'b1;
		end
	end

	// ==========================================================
	// Threshold comparators, evaluated once per sample
	wire signed [SMP_W-1:0] raw_s  = i_raw_smp;
	// Full scale times level over 256: level sits in the top bits
	wire signed [SMP_W-1:0] thr_s  = {adclvl_q, {(SMP_W-9){1'b0}}};
	wire signed [SMP_W:0]   thr_hi = thr_s + $signed({1'b0, `ATU_HYST});
	wire signed [SMP_W:0]   thr_lo = thr_s - $signed({1'b0, `ATU_HYST});
	wire signed [MAG_W-1:0] mag_s  = i_mag_db;
	wire signed [MAG_W-1:0] mlvl_s = maglvl_q;
	reg                     raw_above_q;
	reg                     mag_above_q;
	reg                     panel_d1_q;

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			raw_above_q <= 1'b0;
			mag_above_q <= 1'b0;
			panel_d1_q  <= 1'b0;
		end else begin
			panel_d1_q <= panel_s;
			if (i_smp_valid) begin
				// State only flips past the outer band edge
				if (raw_s > thr_hi)
					raw_above_q <= 1'b1;
				else if (raw_s < thr_lo)
					raw_above_q <= 1'b0;
				mag_above_q <= (mag_s >= mlvl_s);
			end
		end
	end

	// Edge events on the raw, panel and magnitude sources; the instant source is always set
	reg raw_above_d;
	reg mag_above_d;
	reg event_d;
	always @* begin
		raw_above_d = raw_above_q;
		mag_above_d = mag_above_q;
		if (i_smp_valid) begin
			if (raw_s > thr_hi)
				raw_above_d = 1'b1;
			else if (raw_s < thr_lo)
				raw_above_d = 1'b0;
			mag_above_d = (mag_s >= mlvl_s);
		end
		case (src_q)
		`ATU_SRC_NONE:    event_d = 1'b0;
		`ATU_SRC_RAW:     event_d = slope_q ? (raw_above_q & ~raw_above_d)
		                                    : (~raw_above_q & raw_above_d);
		`ATU_SRC_PANEL:   event_d = slope_q ? (panel_d1_q & ~panel_s)
		                                    : (~panel_d1_q & panel_s);
		`ATU_SRC_MAG:     event_d = slope_q ? (mag_above_q & ~mag_above_d)
		                                    : (~mag_above_q & mag_above_d);
		`ATU_SRC_INSTANT: event_d = 1'b1;
		default:          event_d = 1'b0;
		endcase
	end

	// ==========================================================
	// Handshake line control and trigger decision
	reg  trig_done_q;
	wire in_trig = (i_loop_state == `ATU_LOOP_TRIG);
	// At most one trigger per visit: the done flag stops a second fire while the
	// line stays free, which the instant source would otherwise hit again
	wire fire    = in_trig & hs_rel & gen_q & event_d & ~o_trig & ~trig_done_q;

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_trig       <= 1'b0;
			trig_done_q  <= 1'b0;
			o_hs_line_o  <= 1'b0;
			o_hs_line_oe <= 1'b1;
		end else begin
			o_trig <= fire;
			if (!in_trig)
				trig_done_q <= 1'b0;
			else if (fire)
				trig_done_q <= 1'b1;
			o_hs_line_o  <= 1'b0;
			// Hold line low until armed; in trigger state hold while the line reads held, until fired
			o_hs_line_oe <= in_trig ? ~(fire | trig_done_q | hs_rel)
			                        : ~(i_prearm_met & i_loop_state == 2'h1);
		end
	end

	// ==========================================================
	// Fractional delay and oscillator phase capture
	// The count stops at the first output strobe after the fire edge, so it
	// never exceeds the converter samples in one output period
	reg [15:0]     frac_cnt_q;
	reg [15:0]     frac_q;
	reg            frac_run_q;
	reg [PH_W-1:0] phase_q;

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			frac_cnt_q <= 16'h0000;
			frac_q     <= 16'h0000;
			frac_run_q <= 1'b0;
			phase_q    <= {PH_W{1'b0}};
		end else begin
			// Count converter samples from event to next output sample
			if (fire) begin
				frac_cnt_q <= 16'h0000;
				frac_run_q <= 1'b1;
				if (phcap_q)
					phase_q <= i_lo_phase;
			end else if (frac_run_q) begin
				if (i_out_strobe) begin
					frac_q     <= frac_cnt_q;
					frac_run_q <= 1'b0;
				end else if (i_smp_valid)
					frac_cnt_q <= frac_cnt_q + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Status word, readback and lamps
	// Hardware-set waits for an idle command path and an applied setup
	reg hw_set_q;
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hw_set_q      <= 1'b0;
			o_lamp_access <= 1'b0;
			o_lamp_ovl    <= 1'b0;
			o_reg_rdata   <= 16'h0000;
		end else begin
			hw_set_q      <= ~i_cmd_busy & i_hw_applied;
			o_lamp_access <= i_reg_sel;
			o_lamp_ovl    <= i_smp_valid & i_raw_ovl;
			case (i_reg_addr)
			`ATU_REG_STATUS:   o_reg_rdata <= {hw_set_q, ~slot_s,
			                                   i_errq_nonempty,
			                                   o_delay_err, 10'h000, i_loop_state};
			`ATU_REG_TRIG_CFG: o_reg_rdata <= {10'h000, gen_q, slope_q, 1'b0, src_q};
			`ATU_REG_DELAY_LO: o_reg_rdata <= delay_q[15:0];
			`ATU_REG_DELAY_HI: o_reg_rdata <= {{7{delay_q[24]}}, delay_q[24:16]};
			`ATU_REG_ADCLEVEL: o_reg_rdata <= {{7{adclvl_q[8]}}, adclvl_q};
			`ATU_REG_MAGLEVEL: o_reg_rdata <= {{6{maglvl_q[9]}}, maglvl_q};
			`ATU_REG_FRAC:     o_reg_rdata <= frac_q;
			`ATU_REG_PHASE:    o_reg_rdata <= phase_q[PH_W-1 -: 16];
			`ATU_REG_CTRL:     o_reg_rdata <= {15'h0000, phcap_q};
			default:           o_reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule // atu_trigger

/* File: hw/atu_regs.vh */
// Register offsets, field positions, reset values and timing counts for the trigger unit
`ifndef ATU_REGS_VH
`define ATU_REGS_VH
// Register word indices on the 16-bit register bus
`define ATU_REG_STATUS    4'h0
`define ATU_REG_TRIG_CFG  4'h1
`define ATU_REG_DELAY_LO  4'h2
`define ATU_REG_DELAY_HI  4'h3
`define ATU_REG_ADCLEVEL  4'h4
`define ATU_REG_MAGLEVEL  4'h5
`define ATU_REG_FRAC      4'h6
`define ATU_REG_PHASE     4'h7
`define ATU_REG_CTRL      4'h8
// Status word bit positions
`define ATU_ST_ERROR      13
`define ATU_ST_SLOT_N     14
`define ATU_ST_HW_SET     15
// Trigger source codes
`define ATU_SRC_NONE      3'h0
`define ATU_SRC_RAW       3'h1
`define ATU_SRC_PANEL     3'h2
`define ATU_SRC_MAG       3'h3
`define ATU_SRC_INSTANT   3'h4
// Loop states in the status word
`define ATU_LOOP_TRIG     2'h3
// Reset values
`define ATU_RST_SRC       3'h4
`define ATU_RST_DELAY     25'h0000000
`define ATU_RST_ADCLEVEL  9'h000
`define ATU_RST_MAGLEVEL  10'h380
`define ATU_RST_SLOPE     1'b0
`define ATU_RST_GEN       1'b1
// Delay limits
`define ATU_DLY_POST_MAX  25'h0ffff9c
`define ATU_DLY_PRE_BASE  25'h0000084
// Hysteresis half band in raw sample codes
`define ATU_HYST          24'h000100
`endif

/* File: verification/atu_peer_model.sv */
// Peer digitizer model sharing the open-drain handshake line
`timescale 1ns/1ps
module atu_peer_model (
	input  wire logic       i_mclk,
	input  wire logic       i_arst_n,
	input  wire logic       i_armed,
	input  wire logic       i_pull,
	input  wire logic [3:0] i_lag,
	output logic            o_pull_oe
);
	logic [3:0] cnt_q;
	// Hold the line until armed for i_lag cycles; pull on controller command
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q     <= 4'h0;
			o_pull_oe <= 1'b1;
		end else begin
			cnt_q     <= !i_armed ? 4'h0 : (cnt_q == i_lag ? cnt_q : cnt_q + 4'h1);
			o_pull_oe <= i_pull || !(i_armed && cnt_q == i_lag);
		end
	end
endmodule // atu_peer_model

/* File: verification/atu_trigger_chk.sv */
// Port-level assertion checker for the trigger unit
`timescale 1ns/1ps
module atu_trigger_chk #(parameter BUF_BYTES = 32'h00800000) (
	input wire i_mclk, i_arst_n, i_reg_sel, i_reg_wr, i_smp_valid, i_raw_ovl,
	input wire i_errq_nonempty, i_prearm_met, i_slot_select,
	input wire [3:0] i_reg_addr,
	input wire [15:0] i_reg_wdata, o_reg_rdata,
	input wire [1:0] i_loop_state,
	input wire o_hs_line_o, o_hs_line_oe, o_trig, o_delay_err, o_lamp_access, o_lamp_ovl
);
	localparam int LO_LIM = 132 - BUF_BYTES / 8;
	logic [5:0] cfg_q;
	logic [15:0] lo_q;
	wire wr_hi = i_reg_sel && i_reg_wr && i_reg_addr == 4'h3;
	wire signed [24:0] dly = {i_reg_wdata[8:0], lo_q};
	wire bad = dly > 25'sd16777116 || dly < LO_LIM;
	// Shadow of the written trigger settings
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_q <= 6'h24;
			lo_q  <= 16'h0;
		end else if (i_reg_sel && i_reg_wr) begin
			if (i_reg_addr == 4'h1) cfg_q <= i_reg_wdata[5:0];
			if (i_reg_addr == 4'h2) lo_q <= i_reg_wdata;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	AST_LAMP_ACC: assert property (1 |=> o_lamp_access == $past(i_reg_sel))
		else $error("access lamp wrong");
	AST_LAMP_OVL: assert property (i_smp_valid && i_raw_ovl |=> o_lamp_ovl)
		else $error("overload lamp not lit");
	AST_TRIG_ONE: assert property (o_trig |=> !o_trig)
		else $error("trigger pulse too long");
	AST_TRIG_REL: assert property (o_trig |-> !o_hs_line_oe)
		else $error("line held at trigger");
	AST_TRIG_STATE: assert property (o_trig |-> $past(i_loop_state) == 2'h3)
		else $error("trigger outside trigger state");
	AST_TRIG_SRC: assert property (o_trig |-> $past(cfg_q[5]) && $past(cfg_q[2:0]) != 3'h0)
		else $error("trigger while disabled");
	AST_DRV_LOW: assert property (o_hs_line_o == 1'b0)
		else $error("line driven high");
	AST_ERR_BIT: assert property ((i_reg_addr == 4'h0 && $stable(i_errq_nonempty))[*3] |=> o_reg_rdata[13] == $past(i_errq_nonempty))
		else $error("error bit wrong");
	AST_SLOT_BIT: assert property ((i_reg_addr == 4'h0 && $stable(i_slot_select))[*5] |=> o_reg_rdata[14] == !$past(i_slot_select))
		else $error("slot bit wrong");
	AST_BAD_DLY: assert property (wr_hi && bad |=> o_delay_err)
		else $error("bad delay not flagged");
	AST_ARM_REL: assert property ((i_loop_state == 2'h1 && i_prearm_met)[*2] |-> !o_hs_line_oe)
		else $error("armed but line held");
	cover property (o_trig);
	cover property (wr_hi && bad);
	cover property (i_smp_valid && i_raw_ovl);
endmodule // atu_trigger_chk
bind atu_trigger atu_trigger_chk #(.BUF_BYTES(BUF_BYTES)) atu_trigger_chk_inst (.*);

/* File: verification/atu_trigger_tb.sv */
// Self-checking testbench for the trigger unit
`timescale 1ns/1ps
module atu_trigger_tb;
	logic i_mclk, i_arst_n, i_reg_sel, i_reg_wr, i_smp_valid, i_raw_ovl, i_out_strobe;
	logic i_reconfig, i_panel_trig, i_errq_nonempty, i_cmd_busy, i_hw_applied;
	logic i_prearm_met, i_slot_select, i_pull, peer_oe;
	logic [3:0] i_reg_addr, lag;
	logic [15:0] i_reg_wdata, o_reg_rdata, i_lo_phase;
	logic [23:0] i_raw_smp, amp;
	logic [9:0] i_mag_db;
	logic [1:0] i_loop_state;
	logic o_hs_line_o, o_hs_line_oe, o_trig, o_delay_err, o_lamp_access, o_lamp_ovl;
	logic [24:0] dv[5];
	int n_fail, checks_done, fires, seed, i, fc, fr, fr_exp;
	logic [15:0] ph_exp = 16'h0;
	wire hs = !(o_hs_line_oe || peer_oe); // Pulled-up open-drain line
	atu_trigger atu_trigger_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_reg_sel(i_reg_sel),
		.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .i_smp_valid(i_smp_valid), .i_raw_smp(i_raw_smp),
		.i_raw_ovl(i_raw_ovl), .i_mag_db(i_mag_db), .i_out_strobe(i_out_strobe),
		.i_lo_phase(i_lo_phase), .i_reconfig(i_reconfig), .i_panel_trig(i_panel_trig),
		.i_errq_nonempty(i_errq_nonempty), .i_cmd_busy(i_cmd_busy),
		.i_hw_applied(i_hw_applied), .i_loop_state(i_loop_state), .i_prearm_met(i_prearm_met),
		.i_slot_select(i_slot_select), .i_hs_line(hs), .o_hs_line_o(o_hs_line_o),
		.o_hs_line_oe(o_hs_line_oe), .o_trig(o_trig), .o_delay_err(o_delay_err),
		.o_lamp_access(o_lamp_access), .o_lamp_ovl(o_lamp_ovl));
	atu_peer_model atu_peer_model_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_armed(i_prearm_met), .i_pull(i_pull), .i_lag(lag), .o_pull_oe(peer_oe));
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	// Free-running oscillator phase and output strobe
	always @(posedge i_mclk) begin
		i_lo_phase   <= i_lo_phase + 16'h1;
		i_out_strobe <= i_lo_phase[2:0] == 3'h0;
	end
	// Count trigger pulses; the captured phase is the one seen at the fire edge
	always @(negedge i_mclk) begin
		if (o_trig === 1'b1) begin
			fires++;
			ph_exp = i_lo_phase - 16'h1;
		end
	end
	// Reference count of converter samples from trigger to next output sample
	always @(posedge i_mclk) begin
		if (o_trig === 1'b1) begin
			fc = 0;
			fr = 1;
		end
		if (fr == 1 && i_out_strobe === 1'b1) begin
			fr_exp = fc;
			fr = 0;
		end else if (fr == 1 && i_smp_valid === 1'b1)
			fc++;
	end
	// ==========================================
	// Helpers
	function automatic logic [15:0] fire_exp(logic [2:0] s, logic g);
		return (g && s != 3'h0) ? 16'h1 : 16'h0;
	endfunction
	function automatic logic dly_bad(logic signed [24:0] v);
		return v > 25'sd16777116 || v < 132 - $signed(32'h00800000 / 8);
	endfunction
	task automatic chk(logic [15:0] g, logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		{i_reg_sel, i_reg_wr, i_reg_addr, i_reg_wdata} <= {2'b11, a, d};
		@(posedge i_mclk);
		{i_reg_sel, i_reg_wr} <= 2'b00;
		@(posedge i_mclk);
	endtask
	task automatic rchk(logic [3:0] a, logic [15:0] m, logic [15:0] e);
		i_reg_addr <= a;
		repeat (3) @(posedge i_mclk);
		#1 chk(o_reg_rdata & m, e);
		@(posedge i_mclk);
	endtask
	// One arm and trigger visit with events around mid-window
	task automatic visit(logic [2:0] s, logic sl, logic g);
		wr(4'h1, {10'h0, g, sl, 1'b0, s});
		amp = 24'h000200 + ($random(seed) & 24'h00ffff);
		lag = $random(seed) & 4'h3;
		i_loop_state <= 2'h1;
		i_prearm_met <= 1'b1;
		repeat (8) @(posedge i_mclk);
		fires = 0;
		i_loop_state <= 2'h3;
		i_pull <= s == 3'h0;
		for (int k = 0; k < 40; k++) begin
			@(posedge i_mclk);
			i_smp_valid  <= k[1:0] == 2'h0;
			i_raw_ovl    <= k == 24;
			i_raw_smp    <= ((k < 20) ^ sl) ? -amp : amp;
			i_mag_db     <= ((k < 20) ^ sl) ? 10'h338 : 10'h000;
			i_panel_trig <= (k >= 20) ^ sl;
		end
		{i_loop_state, i_prearm_met, i_pull} <= 4'h0;
		repeat (3) @(posedge i_mclk);
		chk(16'(fires), fire_exp(s, g));
		rchk(4'h6, 16'hffff, 16'(fr_exp));
		rchk(4'h7, 16'hffff, ph_exp);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		seed = 33;
		{i_reg_sel, i_reg_wr, i_smp_valid, i_raw_ovl, i_out_strobe, i_reconfig} = 6'h0;
		{i_panel_trig, i_errq_nonempty, i_cmd_busy, i_hw_applied, i_prearm_met} = 5'h0;
		{i_pull, i_arst_n, i_reg_addr, i_reg_wdata, i_lo_phase, i_loop_state} = 0;
		{i_raw_smp, i_mag_db, lag} = 0;
		i_slot_select = 1'b1;
		repeat (20) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		@(posedge i_mclk);
		rchk(4'h1, 16'h0037, 16'h0024);
		rchk(4'h3, 16'h01ff, 16'h0000);
		rchk(4'h4, 16'h01ff, 16'h0000);
		rchk(4'h5, 16'h03ff, 16'h0380);
		rchk(4'h8, 16'h0001, 16'h0001);
		{i_errq_nonempty, i_slot_select, i_hw_applied} <= 3'b101;
		rchk(4'h0, 16'he000, 16'he000);
		{i_errq_nonempty, i_slot_select, i_cmd_busy} <= 3'b011;
		rchk(4'h0, 16'he000, 16'h0000);
		wr(4'hf, 16'hffff);
		rchk(4'hf, 16'hffff, 16'h0000);
		dv = '{25'd16777116, 25'd16777117, -25'sd1048444, -25'sd1048445, $random(seed)};
		for (i = 0; i < 5; i++) begin
			wr(4'h2, dv[i][15:0]);
			wr(4'h3, {7'h0, dv[i][24:16]});
			rchk(4'h2, 16'hffff, dv[i][15:0]);
			rchk(4'h3, 16'h01ff, {7'h0, dv[i][24:16]});
			rchk(4'h0, 16'h1000, {3'h0, dly_bad(dv[i]), 12'h0});
			wr(4'h8, 16'h0003);
		end
		i_reconfig <= 1'b1;
		@(posedge i_mclk);
		i_reconfig <= 1'b0;
		rchk(4'h8, 16'h0001, 16'h0000);
		wr(4'h8, 16'h0001);
		rchk(4'h8, 16'h0001, 16'h0001);
		for (i = 0; i < 5; i++) visit(i[2:0], 1'b0, 1'b1);
		for (i = 1; i < 4; i++) visit(i[2:0], 1'b1, 1'b1);
		visit(3'h4, 1'b0, 1'b0);
		close_out();
	end
endmodule // atu_trigger_tb
